// File: src/isr_consts.svh
// Constants for the slave receive path: field positions, reset values, counts.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ISR_CONSTS_SVH
`define ISR_CONSTS_SVH

// Bit counter for one byte plus its acknowledge slot
`define ISR_BITS_W        4
`define ISR_BYTE_BITS     4'h8
`define ISR_ACK_SLOT      4'h9

// First byte of a 10-bit address carries this prefix in bits 7..3
`define ISR_TEN_PREFIX    5'h1E
`define ISR_ADDR_W        10

// Reset values of the software-visible flags
`define ISR_RST_FULL      1'b0
`define ISR_RST_OVF       1'b0
`define ISR_RST_REL       1'b1

// Entries of the crossing buffer
`define ISR_BUF_DEPTH     2

`endif

// File: src/isr_pkg.sv
// Types shared by the slave receive path.
// Assumes the constants header is compiled alongside; no imports are used.
package isr_pkg;

   // Byte report from the link side to the system side
   typedef struct packed {
      logic [7:0] data;
      logic       is_data;
      logic       read_write;
   } isr_event_t;

   // Status bits that software inspects
   typedef struct packed {
      logic rx_buffer_full;
      logic rx_overflow;
      logic data_not_address;
      logic read_write;
      logic clock_release;
   } isr_status_t;

   typedef enum logic [4:0] {
      ISR_IDLE    = 5'h01,
      ISR_ADDR_HI = 5'h02,
      ISR_ADDR_LO = 5'h04,
      ISR_DATA    = 5'h08,
      ISR_SKIP    = 5'h10
   } isr_mode_t;

endpackage : isr_pkg

// File: src/isr_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset from the parent.
`timescale 1ns/1ps
`default_nettype none
module isr_buf #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic                  wr_ptr;
      logic                  rd_ptr;
      logic [1:0]            count;
   } isr_buf_state_t;

   isr_buf_state_t st;
   isr_buf_state_t next_st;
   logic           push;
   logic           pop;

   assign in_ready  = (st.count != 2'h2);
   assign out_valid = (st.count != 2'h0);
   assign out_data  = st.mem[st.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data;
         next_st.wr_ptr         = ~st.wr_ptr;
      end
      if (pop) begin
         next_st.rd_ptr = ~st.rd_ptr;
      end
      next_st.count = st.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : isr_buf
`default_nettype wire

// File: src/isr_top.sv
// Slave receive path of a two-wire serial port: link logic and software status.
// Assumes link_clk is a free-running sampling clock faster than the bus clock,
// and that address and mode inputs change only while the bus is idle.
`timescale 1ns/1ps
`default_nettype none
`include "isr_consts.svh"
module isr_top (
   // System clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // Bus sampling clock
   input  wire logic                    link_clk,
   // Serial clock pin
   input  wire logic                    serial_clock_pin_in,
   output logic                         serial_clock_pin_out,
   output logic                         serial_clock_pin_oe,
   // Serial data pin
   input  wire logic                    serial_data_pin_in,
   output logic                         serial_data_pin_out,
   output logic                         serial_data_pin_oe,
   // Configuration
   input  wire logic                    ten_bit_mode,
   input  wire logic [`ISR_ADDR_W-1:0]  own_address,
   input  wire logic                    stretch_enable,
   // Software actions, one-cycle pulses
   input  wire logic                    holding_read,
   input  wire logic                    overflow_clear,
   input  wire logic                    release_set,
   input  wire logic                    release_clear,
   // Software view
   output logic [7:0]                   rx_holding_reg,
   output isr_pkg::isr_status_t         slave_status_reg,
   output logic                         slave_irq_flag
);
   typedef struct packed {
      logic                   scl_m;
      logic                   scl_s;
      logic                   scl_d;
      logic                   sda_m;
      logic                   sda_s;
      logic                   sda_d;
      logic                   full_m;
      logic                   full_s;
      logic                   ovf_m;
      logic                   ovf_s;
      logic                   rel_m;
      logic                   rel_s;
      logic                   str_m;
      logic                   str_s;
      logic [`ISR_ADDR_W:0]   cfg_m;
      logic [`ISR_ADDR_W:0]   cfg_s;
      isr_pkg::isr_mode_t     mode;
      logic [`ISR_BITS_W-1:0] bitcnt;
      logic [7:0]             rx_shift_reg;
      logic                   byte_was_data;
      logic                   sda_oe;
      logic                   hold_auto;
      logic                   rel_low_seen;
      logic                   hold_man;
      logic                   scl_oe;
      isr_pkg::isr_event_t    ev;
      logic                   ev_tog;
      logic                   str_tog;
   } isr_link_t;

   typedef struct packed {
      logic                   ev_m;
      logic                   ev_s;
      logic                   ev_d;
      logic                   st_m;
      logic                   st_s;
      logic                   st_d;
      logic                   pend;
      isr_pkg::isr_event_t    pend_ev;
      logic [7:0]             holding;
      isr_pkg::isr_status_t   stat;
      logic                   irq;
   } isr_sys_t;

   logic [1:0]          sys_rst_ff;
   logic [1:0]          link_rst_ff;
   logic                sys_rst_n;
   logic                link_rst_n;
   isr_link_t           l;
   isr_link_t           next_l;
   isr_sys_t            s;
   isr_sys_t            next_s;
   logic                buf_in_ready;
   logic                buf_out_valid;
   logic                buf_out_ready;
   isr_pkg::isr_event_t buf_out;
   logic                pop;

   // Reset release, one synchroniser per domain
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_rst_ff <= 2'h0;
      end else begin
         sys_rst_ff <= {sys_rst_ff[0], 1'b1};
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         link_rst_ff <= 2'h0;
      end else begin
         link_rst_ff <= {link_rst_ff[0], 1'b1};
      end
   end

   assign sys_rst_n  = sys_rst_ff[1];
   assign link_rst_n = link_rst_ff[1];

   // Link side: bus sampling, byte framing, acknowledge and clock hold
   function automatic logic [`ISR_BITS_W-1:0] isr_inc(input logic [`ISR_BITS_W-1:0] v);
      isr_inc = v + `ISR_BITS_W'(1);
   endfunction : isr_inc

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic ack_now;

   assign scl_rise  = l.scl_s && !l.scl_d;
   assign scl_fall  = !l.scl_s && l.scl_d;
   assign bus_start = l.scl_s && l.scl_d && l.sda_d && !l.sda_s;
   assign bus_stop  = l.scl_s && l.scl_d && !l.sda_d && l.sda_s;

   always_comb begin
      next_l = l;
      ack_now = 1'b0;
      next_l.scl_m  = serial_clock_pin_in;
      next_l.scl_s  = l.scl_m;
      next_l.scl_d  = l.scl_s;
      next_l.sda_m  = serial_data_pin_in;
      next_l.sda_s  = l.sda_m;
      next_l.sda_d  = l.sda_s;
      next_l.full_m = s.stat.rx_buffer_full;
      next_l.full_s = l.full_m;
      next_l.ovf_m  = s.stat.rx_overflow;
      next_l.ovf_s  = l.ovf_m;
      next_l.rel_m  = s.stat.clock_release;
      next_l.rel_s  = l.rel_m;
      next_l.str_m  = stretch_enable;
      next_l.str_s  = l.str_m;
      next_l.cfg_m  = {ten_bit_mode, own_address};
      next_l.cfg_s  = l.cfg_m;
      if (bus_stop) begin
         next_l.mode      = isr_pkg::ISR_IDLE;
         next_l.bitcnt    = '0;
         next_l.sda_oe    = 1'b0;
         next_l.hold_auto = 1'b0;
      end else if (bus_start) begin
         next_l.mode   = isr_pkg::ISR_ADDR_HI;
         next_l.bitcnt = '0;
         next_l.sda_oe = 1'b0;
      end else if (l.mode != isr_pkg::ISR_IDLE) begin
         if (scl_rise && l.bitcnt < `ISR_BYTE_BITS) begin
            next_l.rx_shift_reg = {l.rx_shift_reg[6:0], l.sda_s};
            next_l.bitcnt       = isr_inc(l.bitcnt);
         end else if (scl_rise && l.bitcnt == `ISR_BYTE_BITS) begin
            next_l.bitcnt = isr_inc(l.bitcnt);
         end
         if (scl_fall && l.bitcnt == `ISR_BYTE_BITS) begin
            next_l.byte_was_data = 1'b0;
            unique case (l.mode)
               isr_pkg::ISR_ADDR_HI: begin
                  if (l.cfg_s[`ISR_ADDR_W]) begin
                     // 10-bit write only; reads after restart are not served
                     if (l.rx_shift_reg[7:3] == `ISR_TEN_PREFIX &&
                         l.rx_shift_reg[2:1] == l.cfg_s[9:8] &&
                         !l.rx_shift_reg[0]) begin
                        ack_now     = 1'b1;
                        next_l.mode = isr_pkg::ISR_ADDR_LO;
                     end else begin
                        next_l.mode = isr_pkg::ISR_SKIP;
                     end
                  end else if (l.rx_shift_reg[7:1] == l.cfg_s[6:0]) begin
                     ack_now                  = 1'b1;
                     next_l.ev.data           = l.rx_shift_reg;
                     next_l.ev.is_data        = 1'b0;
                     next_l.ev.read_write     = l.rx_shift_reg[0];
                     next_l.ev_tog            = ~l.ev_tog;
                     // No transmit path, so a read is reported then ignored
                     next_l.mode = l.rx_shift_reg[0] ? isr_pkg::ISR_SKIP
                                                     : isr_pkg::ISR_DATA;
                  end else begin
                     next_l.mode = isr_pkg::ISR_SKIP;
                  end
               end
               isr_pkg::ISR_ADDR_LO: begin
                  if (l.rx_shift_reg == l.cfg_s[7:0]) begin
                     ack_now              = 1'b1;
                     next_l.ev.data       = l.rx_shift_reg;
                     next_l.ev.is_data    = 1'b0;
                     next_l.ev.read_write = 1'b0;
                     next_l.ev_tog        = ~l.ev_tog;
                     next_l.mode          = isr_pkg::ISR_DATA;
                  end else begin
                     next_l.mode = isr_pkg::ISR_SKIP;
                  end
               end
               isr_pkg::ISR_DATA: begin
                  ack_now              = !(l.full_s || l.ovf_s);
                  next_l.byte_was_data = 1'b1;
                  next_l.ev.data       = l.rx_shift_reg;
                  next_l.ev.is_data    = 1'b1;
                  next_l.ev.read_write = 1'b0;
                  next_l.ev_tog        = ~l.ev_tog;
               end
               isr_pkg::ISR_SKIP: begin
               end
               default: begin
                  next_l.mode = isr_pkg::ISR_IDLE;
               end
            endcase
            next_l.sda_oe = ack_now;
         end else if (scl_fall && l.bitcnt == `ISR_ACK_SLOT) begin
            next_l.sda_oe = 1'b0;
            next_l.bitcnt = '0;
            // Full flag is sampled here, so a read before this edge avoids the hold
            if (l.byte_was_data && l.str_s && l.full_s) begin
               next_l.hold_auto    = 1'b1;
               next_l.rel_low_seen = 1'b0;
               next_l.str_tog      = ~l.str_tog;
            end
         end
      end
      // Automatic hold ends once release has been seen low then high again
      if (l.hold_auto) begin
         if (!l.rel_s) begin
            next_l.rel_low_seen = 1'b1;
         end else if (l.rel_low_seen) begin
            next_l.hold_auto    = 1'b0;
            next_l.rel_low_seen = 1'b0;
         end
      end
      next_l.hold_man = !l.rel_s && (l.hold_man || !l.scl_s);
      next_l.scl_oe   = next_l.hold_auto || next_l.hold_man;
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         l        <= '0;
         l.scl_m  <= 1'b1;
         l.scl_s  <= 1'b1;
         l.scl_d  <= 1'b1;
         l.sda_m  <= 1'b1;
         l.sda_s  <= 1'b1;
         l.sda_d  <= 1'b1;
         l.rel_m  <= `ISR_RST_REL;
         l.rel_s  <= `ISR_RST_REL;
         l.mode   <= isr_pkg::ISR_IDLE;
         l.scl_oe <= 1'b0;
      end else begin
         l <= next_l;
      end
   end

   // System side: byte reports cross by toggle, then pass the buffer
   isr_buf #(
      .WIDTH ($bits(isr_pkg::isr_event_t))
   ) u_buf (
      .clk       (clk),
      .rst_n     (sys_rst_n),
      .in_valid  (s.pend),
      .in_ready  (buf_in_ready),
      .in_data   (s.pend_ev),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out)
   );

   // Drain stalls on a software read so full is never set and cleared at once
   assign buf_out_ready = !holding_read;
   assign pop           = buf_out_valid && buf_out_ready;

   always_comb begin
      next_s = s;
      next_s.irq  = 1'b0;
      next_s.ev_m = l.ev_tog;
      next_s.ev_s = s.ev_m;
      next_s.ev_d = s.ev_s;
      next_s.st_m = l.str_tog;
      next_s.st_s = s.st_m;
      next_s.st_d = s.st_s;
      if (s.pend && buf_in_ready) begin
         next_s.pend = 1'b0;
      end
      // Report word is held stable by the link for a whole byte time
      if (s.ev_s != s.ev_d) begin
         next_s.pend    = 1'b1;
         next_s.pend_ev = l.ev;
      end
      if (holding_read) begin
         next_s.stat.rx_buffer_full = 1'b0;
      end
      if (overflow_clear) begin
         next_s.stat.rx_overflow = 1'b0;
      end
      if (pop) begin
         next_s.irq = 1'b1;
         if (buf_out.is_data) begin
            next_s.stat.data_not_address = 1'b1;
            next_s.stat.read_write       = 1'b0;
            if (!s.stat.rx_buffer_full) begin
               next_s.holding             = buf_out.data;
               next_s.stat.rx_buffer_full = 1'b1;
            end else begin
               next_s.stat.rx_overflow = 1'b1;
            end
         end else begin
            next_s.stat.data_not_address = 1'b0;
            next_s.stat.read_write       = buf_out.read_write;
         end
      end
      if (s.st_s != s.st_d || release_clear) begin
         next_s.stat.clock_release = 1'b0;
      end
      if (release_set) begin
         next_s.stat.clock_release = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!sys_rst_n) begin
         s                     <= '0;
         s.stat.rx_buffer_full <= `ISR_RST_FULL;
         s.stat.rx_overflow    <= `ISR_RST_OVF;
         s.stat.clock_release  <= `ISR_RST_REL;
      end else begin
         s <= next_s;
      end
   end

   assign serial_clock_pin_out = 1'b0;
   assign serial_clock_pin_oe  = l.scl_oe;
   assign serial_data_pin_out  = 1'b0;
   assign serial_data_pin_oe   = l.sda_oe;
   assign rx_holding_reg       = s.holding;
   assign slave_status_reg     = s.stat;
   assign slave_irq_flag       = s.irq;

   // Checks on the system side
   irq_per_byte_a: assert property (
      @(posedge clk) disable iff (!sys_rst_n)
      pop |=> slave_irq_flag) else $error("byte report without interrupt");

   load_byte_a: assert property (
      @(posedge clk) disable iff (!sys_rst_n)
      pop && buf_out.is_data && !slave_status_reg.rx_buffer_full
      |=> slave_status_reg.rx_buffer_full && slave_status_reg.data_not_address &&
          rx_holding_reg == $past(buf_out.data)) else $error("data byte not loaded");

   overrun_keep_a: assert property (
      @(posedge clk) disable iff (!sys_rst_n)
      pop && buf_out.is_data && slave_status_reg.rx_buffer_full
      |=> $stable(rx_holding_reg) && slave_status_reg.rx_overflow)
      else $error("overrun changed holding byte");

   read_clears_a: assert property (
      @(posedge clk) disable iff (!sys_rst_n)
      holding_read && slave_status_reg.rx_overflow && !overflow_clear
      |=> !slave_status_reg.rx_buffer_full && slave_status_reg.rx_overflow)
      else $error("read did not clear full or dropped overflow");

   ovf_sticky_a: assert property (
      @(posedge clk) disable iff (!sys_rst_n)
      $fell(slave_status_reg.rx_overflow) |-> $past(overflow_clear))
      else $error("overflow cleared without software");

   addr_class_a: assert property (
      @(posedge clk) disable iff (!sys_rst_n)
      pop && !buf_out.is_data
      |=> !slave_status_reg.data_not_address && slave_irq_flag)
      else $error("address byte misclassified");

   // Checks on the link side
   nack_full_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      scl_fall && l.bitcnt == `ISR_BYTE_BITS && l.mode == isr_pkg::ISR_DATA && l.full_s
      |=> !serial_data_pin_oe) else $error("full buffer byte acknowledged");

   auto_hold_cause_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      $rose(l.hold_auto) |-> $past(l.str_s) && $past(l.full_s))
      else $error("clock held without stretching enabled");

   manual_low_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      $rose(l.hold_man) |-> !$past(l.scl_s) && !$past(l.rel_s))
      else $error("manual hold began with clock high");

   // A hold that starts on this edge is a fresh stretch, not a missed release
   release_free_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      l.rel_s && !next_l.hold_auto |=> !serial_clock_pin_oe)
      else $error("clock still held after release");
endmodule : isr_top
`default_nettype wire

// File: verif/isr_master.sv
// Behavioural bus master for the slave receive path: start, byte, stop.
// Assumes pull-ups on both wires; the bench resolves the wire levels.
`timescale 1ns/1ps
`default_nettype none
module isr_master (
   // Resolved wire levels
   input  wire logic scl,
   input  wire logic sda,
   // Open-drain pulls
   output logic      scl_low,
   output logic      sda_low
);
   localparam int Q = 1000;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Waits out a stretch, bounded so a stuck hold still ends
   task automatic clock_high();
      int n;
      n = 0;
      scl_low = 1'b0;
      while (scl !== 1'b1 && n < 20000) begin
         #10;
         n++;
      end
      #(2*Q);
   endtask : clock_high
   task automatic start();
      sda_low = 1'b1;
      #Q;
      scl_low = 1'b1;
      #Q;
   endtask : start
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = !b[i];
         #Q;
         clock_high();
         scl_low = 1'b1;
         #Q;
      end
      sda_low = 1'b0;
      #Q;
      clock_high();
      ack = !sda;
      scl_low = 1'b1;
      #Q;
   endtask : send
   task automatic stop();
      sda_low = 1'b1;
      #Q;
      clock_high();
      sda_low = 1'b0;
      #Q;
   endtask : stop
endmodule : isr_master
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the slave receive path, with a behavioural master.
// Assumes the constants header, package and design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
   logic ten_bit_mode = 1'b0, stretch_enable = 1'b0, holding_read = 1'b0;
   logic overflow_clear = 1'b0, release_set = 1'b0, release_clear = 1'b0;
   logic [9:0] own_address = 10'h05A;
   logic rd_req = 1'b0, auto_read = 1'b0, ack, irq;
   logic scl_oe, sda_oe, m_scl, m_sda, scl, sda, scl_out, sda_out;
   logic [7:0] rx;
   isr_pkg::isr_status_t st;
   int irqs = 0, holds = 0, errors = 0, checks_done = 0;
   always #50 clk = ~clk;
   initial begin
      #17;
      forever #40 link_clk = ~link_clk;
   end
   assign scl = !(m_scl | scl_oe);
   assign sda = !(m_sda | sda_oe);
   isr_top uut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
      .serial_clock_pin_in(scl), .serial_clock_pin_out(scl_out), .serial_clock_pin_oe(scl_oe),
      .serial_data_pin_in(sda), .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
      .ten_bit_mode(ten_bit_mode), .own_address(own_address),
      .stretch_enable(stretch_enable), .holding_read(holding_read),
      .overflow_clear(overflow_clear), .release_set(release_set),
      .release_clear(release_clear), .rx_holding_reg(rx), .slave_status_reg(st),
      .slave_irq_flag(irq));
   isr_master m (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
   // Auto read answers each interrupt, as fast software would
   always @(posedge clk) begin
      holding_read <= rd_req | (auto_read & irq);
      if (irq === 1'b1) irqs <= irqs + 1;
      if (scl_oe === 1'b1) holds <= holds + 1;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("errors %0d, checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // Pulses: read, overflow clear, release set, release clear
   task automatic sw(input logic [3:0] p);
      @(posedge clk);
      {rd_req, overflow_clear, release_set, release_clear} <= p;
      @(posedge clk);
      {rd_req, overflow_clear, release_set, release_clear} <= 4'h0;
      repeat (4) @(posedge clk);
   endtask : sw
   task automatic tx(input logic [7:0] b, input logic a);
      m.send(b, ack);
      check(ack, a);
   endtask : tx
   task automatic s_seven();
      int c0, h0;
      c0 = irqs;
      h0 = holds;
      m.start();
      tx(8'hB4, 1'b1);
      check(8'(irqs - c0), 8'h01);
      check({st.data_not_address, st.read_write}, 8'h00);
      tx(8'h3C, 1'b1);
      check(rx, 8'h3C);
      check({st.rx_buffer_full, st.data_not_address}, 8'h03);
      sw(4'h8);
      check(st.rx_buffer_full, 1'b0);
      tx(8'hC3, 1'b1);
      check(8'(irqs - c0), 8'h03);
      m.stop();
      sw(4'h8);
      check(8'(holds - h0), 8'h00);
      m.start();
      tx(8'hB5, 1'b1);
      check({st.data_not_address, st.read_write}, 8'h01);
      m.stop();
   endtask : s_seven
   task automatic s_overrun();
      int c0;
      c0 = irqs;
      m.start();
      tx(8'hB4, 1'b1);
      tx(8'h11, 1'b1);
      tx(8'h22, 1'b0);
      check(st.rx_overflow, 1'b1);
      check(rx, 8'h11);
      tx(8'h33, 1'b0);
      check(8'(irqs - c0), 8'h04);
      sw(4'h8);
      check({st.rx_buffer_full, st.rx_overflow}, 8'h01);
      sw(4'h4);
      check(st.rx_overflow, 1'b0);
      tx(8'h44, 1'b1);
      check(rx, 8'h44);
      m.stop();
      sw(4'h8);
   endtask : s_overrun
   task automatic s_ten();
      int c0;
      @(posedge clk);
      ten_bit_mode <= 1'b1;
      own_address <= 10'h2A5;
      repeat (4) @(posedge clk);
      c0 = irqs;
      m.start();
      tx(8'hF4, 1'b1);
      check(8'(irqs - c0), 8'h00);
      tx(8'hA5, 1'b1);
      check(8'(irqs - c0), 8'h01);
      tx(8'h5A, 1'b1);
      check(rx, 8'h5A);
      m.stop();
      sw(4'h8);
      ten_bit_mode <= 1'b0;
      own_address <= 10'h05A;
   endtask : s_ten
   task automatic s_stretch();
      @(posedge clk);
      stretch_enable <= 1'b1;
      m.start();
      tx(8'hB4, 1'b1);
      tx(8'h5A, 1'b1);
      repeat (10) @(posedge clk);
      check({scl_oe, st.clock_release}, 8'h02);
      sw(4'hA);
      repeat (10) @(posedge clk);
      check(scl_oe, 1'b0);
      auto_read <= 1'b1;
      tx(8'hA5, 1'b1);
      repeat (10) @(posedge clk);
      check(scl_oe, 1'b0);
      m.stop();
      @(posedge clk);
      auto_read <= 1'b0;
      stretch_enable <= 1'b0;
   endtask : s_stretch
   task automatic s_manual();
      sw(4'h1);
      repeat (20) @(posedge clk);
      check({scl_oe, st.clock_release}, 8'h00);
      fork
         begin
            m.start();
            m.send(8'hB4, ack);
         end
         begin
            repeat (40) @(posedge clk);
            check(scl_oe, 1'b1);
            sw(4'h2);
         end
      join
      check({ack, st.clock_release}, 8'h03);
      m.stop();
   endtask : s_manual
   initial begin
      #5000000;
      errors++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (10) @(posedge clk);
      check(st, 8'h01);
      check({scl_oe, sda_oe}, 8'h00);
      check({scl_out, sda_out}, 8'h00);
      s_seven();
      s_overrun();
      s_ten();
      s_stretch();
      s_manual();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
